// ---- lpdpc_pkg.sv ----
// Constants and types for the LPDDR2 power-state and command-gating block
// Functional notes
// - ZQ tied high means calibration commands ignored
// - CKE low with CS# high enters power-down
// - Idle or active power-down by open rows
// - Power-down disables buffers except CK and CKE
// - No refresh performed while in power-down
// - CKE high exits power-down; commands after tXP
// - CKE low, CS# low, CA 110 enters deep power-down
// - Deep power-down loses array, disables buffers, power
// - Deep power-down exit needs full reinitialization
// - NOP decoded only with steady CKE; no abort
package lpdpc_pkg;
  typedef enum logic [2:0] {
    LPDPC_ACTIVE_ST = 3'h0,
    LPDPC_PD_IDLE   = 3'h1,
    LPDPC_PD_ACT    = 3'h2,
    LPDPC_DPD       = 3'h3,
    LPDPC_NEED_INIT = 3'h4
  } lpdpc_state_type;

  // Command decode codes
  typedef enum logic [2:0] {
    LPDPC_CMD_NONE = 3'h0,
    LPDPC_CMD_NOP  = 3'h1,
    LPDPC_CMD_ACT  = 3'h2,
    LPDPC_CMD_PRE  = 3'h3,
    LPDPC_CMD_REF  = 3'h4,
    LPDPC_CMD_MRW  = 3'h5,
    LPDPC_CMD_OTH  = 3'h6
  } lpdpc_cmd_type;

  localparam int          LPDPC_CLK_MHZ  = 100;
  localparam int          LPDPC_TXP_NS   = 8;
  localparam int          LPDPC_TXP_CYC  = (LPDPC_TXP_NS * LPDPC_CLK_MHZ + 999) / 1000;
  localparam logic [3:0]  LPDPC_TXP_CNT  = 4'(LPDPC_TXP_CYC < 1 ? 1 : LPDPC_TXP_CYC);
  localparam logic [3:0]  LPDPC_ZERO4    = 4'h0;
  localparam logic [3:0]  LPDPC_ONE4     = 4'h1;
  localparam logic [3:0]  LPDPC_MA_ZQ    = 4'h0;
  localparam logic [7:0]  LPDPC_ZQ_MA    = 8'h0a;
  localparam logic [7:0]  LPDPC_RST_ZERO = 8'h00;
endpackage

// ---- lpdpc_cmd_dec.sv ----
// Command decoder for the CA bus
`timescale 1ns/1ps
module lpdpc_cmd_dec (
  input  wire logic                    cs_n_in,
  input  wire logic [9:0]              ca_in,
  output lpdpc_pkg::lpdpc_cmd_type     cmd_out
);
  always_comb begin
    cmd_out = lpdpc_pkg::LPDPC_CMD_OTH;
    if (cs_n_in) begin
      cmd_out = lpdpc_pkg::LPDPC_CMD_NOP;
    end else if (ca_in[2:0] == 3'h7) begin
      cmd_out = lpdpc_pkg::LPDPC_CMD_NOP;
    end else if (ca_in[1:0] == 2'h2) begin
      cmd_out = lpdpc_pkg::LPDPC_CMD_ACT;
    end else if (ca_in[3:0] == 4'hb) begin
      cmd_out = lpdpc_pkg::LPDPC_CMD_PRE;
    end else if (ca_in[3:0] == 4'h3) begin
      cmd_out = lpdpc_pkg::LPDPC_CMD_REF;
    end else if (ca_in[3:0] == 4'h0) begin
      cmd_out = lpdpc_pkg::LPDPC_CMD_MRW;
    end
  end
endmodule

// ---- lpdpc_ctrl.sv ----
// Power-down, deep power-down and command gating state machine
`timescale 1ns/1ps
module lpdpc_ctrl #(
  parameter int NUM_BANKS = 4
) (
  input  wire logic                 clk_in,
  input  wire logic                 resetn_in,
  input  wire logic                 cke_in,
  input  wire logic                 cs_n_in,
  input  wire logic [9:0]           ca_in,
  input  wire logic                 zq_tied_high_in,
  input  wire logic [NUM_BANKS-1:0] bank_open_in,
  input  wire logic                 init_done_in,
  output logic                      power_down_out,
  output logic                      active_pd_out,
  output logic                      deep_pd_out,
  output logic                      buffers_on_out,
  output logic                      core_power_on_out,
  output logic                      array_valid_out,
  output logic                      refresh_allow_out,
  output logic                      cmd_valid_out,
  output lpdpc_pkg::lpdpc_cmd_type  cmd_out,
  output logic                      zq_cal_start_out,
  output logic                      nop_out
);
  lpdpc_pkg::lpdpc_state_type state_r, state_nxt;
  lpdpc_pkg::lpdpc_cmd_type   dec_cmd;
  logic                       cke_prev_r, cke_prev_nxt;
  logic [3:0]                 txp_r, txp_nxt;
  logic                       arr_r, arr_nxt;
  logic                       cv_r, cv_nxt;
  lpdpc_pkg::lpdpc_cmd_type   cmd_r, cmd_nxt;
  logic                       zq_r, zq_nxt;
  logic                       nop_r, nop_nxt;
  logic                       any_open;
  logic                       cke_steady;
  logic                       dpd_code;

  lpdpc_cmd_dec u_dec (
    .cs_n_in (cs_n_in),
    .ca_in   (ca_in),
    .cmd_out (dec_cmd)
  );

  assign any_open   = |bank_open_in;
  assign cke_steady = cke_in && cke_prev_r;
  assign dpd_code   = !cs_n_in && (ca_in[2:0] == 3'h3);

  always_comb begin
    state_nxt    = state_r;
    cke_prev_nxt = cke_in;
    txp_nxt      = (txp_r != lpdpc_pkg::LPDPC_ZERO4) ? txp_r - lpdpc_pkg::LPDPC_ONE4 : txp_r;
    arr_nxt      = arr_r;
    cv_nxt       = 1'b0;
    cmd_nxt      = lpdpc_pkg::LPDPC_CMD_NONE;
    zq_nxt       = 1'b0;
    nop_nxt      = 1'b0;
    unique case (state_r)
      lpdpc_pkg::LPDPC_ACTIVE_ST: begin
        if (!cke_in && cke_prev_r && dpd_code) begin
          state_nxt = lpdpc_pkg::LPDPC_DPD;
          arr_nxt   = 1'b0;
        end else if (!cke_in && cke_prev_r && cs_n_in) begin
          state_nxt = any_open ? lpdpc_pkg::LPDPC_PD_ACT
                               : lpdpc_pkg::LPDPC_PD_IDLE;
        end else if (cke_steady && txp_r == lpdpc_pkg::LPDPC_ZERO4) begin
          cv_nxt  = (dec_cmd != lpdpc_pkg::LPDPC_CMD_NOP);
          cmd_nxt = dec_cmd;
          nop_nxt = (dec_cmd == lpdpc_pkg::LPDPC_CMD_NOP);
          if (dec_cmd == lpdpc_pkg::LPDPC_CMD_MRW && !cs_n_in
              && {ca_in[9:4], 2'h0} == 8'h28) begin
            zq_nxt = !zq_tied_high_in;
          end
        end
      end
      lpdpc_pkg::LPDPC_PD_IDLE, lpdpc_pkg::LPDPC_PD_ACT: begin
        if (cke_in) begin
          state_nxt = lpdpc_pkg::LPDPC_ACTIVE_ST;
          txp_nxt   = lpdpc_pkg::LPDPC_TXP_CNT;
        end
      end
      lpdpc_pkg::LPDPC_DPD: begin
        if (cke_in) begin
          state_nxt = lpdpc_pkg::LPDPC_NEED_INIT;
        end
      end
      lpdpc_pkg::LPDPC_NEED_INIT: begin
        if (init_done_in) begin
          state_nxt = lpdpc_pkg::LPDPC_ACTIVE_ST;
          arr_nxt   = 1'b1;
        end
      end
      default: begin
        state_nxt = lpdpc_pkg::LPDPC_NEED_INIT;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r    <= lpdpc_pkg::LPDPC_ACTIVE_ST;
      cke_prev_r <= 1'b1;
      txp_r      <= 4'h0;
      arr_r      <= 1'b1;
      cv_r       <= 1'b0;
      cmd_r      <= lpdpc_pkg::LPDPC_CMD_NONE;
      zq_r       <= 1'b0;
      nop_r      <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      cke_prev_r <= cke_prev_nxt;
      txp_r      <= txp_nxt;
      arr_r      <= arr_nxt;
      cv_r       <= cv_nxt;
      cmd_r      <= cmd_nxt;
      zq_r       <= zq_nxt;
      nop_r      <= nop_nxt;
    end
  end

  always_comb begin
    power_down_out    = (state_r == lpdpc_pkg::LPDPC_PD_IDLE)
                     || (state_r == lpdpc_pkg::LPDPC_PD_ACT);
    active_pd_out     = (state_r == lpdpc_pkg::LPDPC_PD_ACT);
    deep_pd_out       = (state_r == lpdpc_pkg::LPDPC_DPD);
    buffers_on_out    = !power_down_out && !deep_pd_out;
    core_power_on_out = !deep_pd_out;
    array_valid_out   = arr_r;
    refresh_allow_out = (state_r == lpdpc_pkg::LPDPC_ACTIVE_ST);
    cmd_valid_out     = cv_r;
    cmd_out           = cmd_r;
    zq_cal_start_out  = zq_r;
    nop_out           = nop_r;
  end

  pd_entry_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state_r == lpdpc_pkg::LPDPC_ACTIVE_ST && !cke_in && cke_prev_r && cs_n_in)
    |=> power_down_out)
    else $error("Power-down not entered");
  pd_kind_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state_r == lpdpc_pkg::LPDPC_ACTIVE_ST && !cke_in && cke_prev_r && cs_n_in
     && !any_open) |=> (power_down_out && !active_pd_out))
    else $error("Idle power-down misclassified");
  pd_buffers_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    power_down_out |-> (!buffers_on_out && !cmd_valid_out ##1 !cmd_valid_out))
    else $error("Buffers active in power-down");
  no_refresh_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    power_down_out |-> !refresh_allow_out)
    else $error("Refresh allowed in power-down");
  pd_exit_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (power_down_out && cke_in) |=> (!power_down_out && !cmd_valid_out ##1 !cmd_valid_out))
    else $error("Power-down exit or tXP wrong");
  dpd_entry_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state_r == lpdpc_pkg::LPDPC_ACTIVE_ST && !cke_in && cke_prev_r && dpd_code)
    |=> (deep_pd_out && !array_valid_out && !core_power_on_out))
    else $error("Deep power-down not entered");
  dpd_exit_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (deep_pd_out && cke_in) |=> (!deep_pd_out && !refresh_allow_out && !array_valid_out))
    else $error("Deep power-down exit skipped init");
  zq_ignore_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $past(zq_tied_high_in) |-> !zq_cal_start_out)
    else $error("ZQ command not ignored");
  nop_steady_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    nop_out |-> $past(cke_in, 2) && $past(cke_in))
    else $error("NOP decoded with changing CKE");
endmodule

// ---- lpdpc_host_model.sv ----
// Memory controller model driving CKE, CS# and CA
`timescale 1ns/1ps
module lpdpc_host_model (
  input  wire logic       clk_in,
  output logic            cke_out,
  output logic            cs_n_out,
  output logic [9:0]      ca_out
);
  initial begin
    cke_out  = 1'b1;
    cs_n_out = 1'b1;
    ca_out   = 10'h000;
  end

  // One command slot per clock, changed just after the edge
  // CKE only dropped with no burst or mode access pending
  // CA toggles while deselected so no stale value is seen
  task automatic drive(input logic cke, input logic cs_n, input logic [9:0] ca);
    @(posedge clk_in);
    #1;
    cke_out  = cke;
    cs_n_out = cs_n;
    ca_out   = cs_n ? ~ca_out : ca;
  endtask
endmodule

// ---- lpdpc_ctrl_tb_top.sv ----
// Self-checking bench for the power-state and command-gating block
`timescale 1ns/1ps
module lpdpc_ctrl_tb_top;
  typedef struct packed {
    logic       cs_n;
    logic [9:0] ca;
    logic       zq_tied;
    logic [2:0] exp_cmd;
    logic       exp_valid;
    logic       exp_nop;
    logic       exp_zq;
  } lpdpc_row_type;
  logic                     clk_in, resetn_in, zq_tied, init_done, cke, cs_n;
  logic [9:0]               ca;
  logic [3:0]               banks;
  logic                     pd, apd, dpd, buf_on, pwr_on, arr_ok, ref_ok, valid, zq, nop;
  lpdpc_pkg::lpdpc_cmd_type cmd;
  lpdpc_row_type            rows [9];
  int                       mismatches, checks_done;
  wire [7:0]                st = {1'b0, pd, apd, dpd, buf_on, pwr_on, arr_ok, ref_ok};

  lpdpc_ctrl #(.NUM_BANKS(4)) DUT (.clk_in(clk_in), .resetn_in(resetn_in), .cke_in(cke),
    .cs_n_in(cs_n), .ca_in(ca), .zq_tied_high_in(zq_tied), .bank_open_in(banks),
    .init_done_in(init_done), .power_down_out(pd), .active_pd_out(apd), .deep_pd_out(dpd),
    .buffers_on_out(buf_on), .core_power_on_out(pwr_on), .array_valid_out(arr_ok),
    .refresh_allow_out(ref_ok), .cmd_valid_out(valid), .cmd_out(cmd),
    .zq_cal_start_out(zq), .nop_out(nop));
  lpdpc_host_model host (.clk_in(clk_in), .cke_out(cke), .cs_n_out(cs_n), .ca_out(ca));

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Command slot followed by a deselect slot
  task automatic slot(input logic k, input logic c, input logic [9:0] a);
    host.drive(k, c, a);
    host.drive(k, 1'b1, 10'h000);
  endtask

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial begin
    #100000;
    mismatches++;
    finish_test;
  end

  initial begin
    resetn_in = 1'b0; zq_tied = 1'b0; init_done = 1'b0; banks = 4'h0;
    mismatches = 0; checks_done = 0;
    rows[0] = '{1'b1, 10'h000, 1'b0, 3'h1, 1'b0, 1'b1, 1'b0};
    rows[1] = '{1'b0, 10'h007, 1'b0, 3'h1, 1'b0, 1'b1, 1'b0};
    rows[2] = '{1'b0, 10'h002, 1'b0, 3'h2, 1'b1, 1'b0, 1'b0};
    rows[3] = '{1'b0, 10'h00b, 1'b0, 3'h3, 1'b1, 1'b0, 1'b0};
    rows[4] = '{1'b0, 10'h003, 1'b0, 3'h4, 1'b1, 1'b0, 1'b0};
    rows[5] = '{1'b0, 10'h0a0, 1'b0, 3'h5, 1'b1, 1'b0, 1'b1};
    rows[6] = '{1'b0, 10'h0a0, 1'b1, 3'h5, 1'b1, 1'b0, 1'b0};
    rows[7] = '{1'b0, 10'h000, 1'b0, 3'h5, 1'b1, 1'b0, 1'b0};
    rows[8] = '{1'b0, 10'h005, 1'b0, 3'h6, 1'b1, 1'b0, 1'b0};
    repeat (5) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    chk("reset", st, 8'h0f);
    for (int i = 0; i < 9; i++) begin
      zq_tied = rows[i].zq_tied;
      slot(1'b1, rows[i].cs_n, rows[i].ca);
      chk("valid", valid, rows[i].exp_valid);
      chk("nop", nop, rows[i].exp_nop);
      chk("cmd", cmd, rows[i].exp_cmd);
      chk("zq", zq, rows[i].exp_zq);
    end
    zq_tied = 1'b0;
    // Idle then active power-down, exit and latency
    for (int i = 0; i < 2; i++) begin
      banks = i ? 4'h2 : 4'h0;
      host.drive(1'b0, 1'b1, 10'h000);
      host.drive(1'b0, 1'b1, 10'h000);
      slot(1'b0, 1'b0, 10'h002);
      chk("pd", st, i ? 8'h66 : 8'h46);
      chk("pdcmd", valid, 8'h00);
      host.drive(1'b1, 1'b1, 10'h000);
      host.drive(1'b1, 1'b0, 10'h002);
      chk("exit", st, 8'h0f);
      chk("exitnop", nop, 8'h00);
      chk("exitcmd", valid, 8'h00);
      host.drive(1'b1, 1'b1, 10'h000);
      chk("txp", valid, 8'h00);
      slot(1'b1, 1'b0, 10'h002);
      chk("act", valid, 8'h01);
    end
    banks = 4'h0;
    // Deep power-down and reinitialization
    host.drive(1'b0, 1'b0, 10'h003);
    host.drive(1'b0, 1'b1, 10'h000);
    slot(1'b0, 1'b0, 10'h002);
    chk("dpd", st, 8'h10);
    chk("dpdcmd", valid, 8'h00);
    host.drive(1'b1, 1'b1, 10'h000);
    repeat (2) slot(1'b1, 1'b0, 10'h002);
    chk("init", st, 8'h0c);
    chk("initcmd", valid, 8'h00);
    init_done = 1'b1;
    host.drive(1'b1, 1'b1, 10'h000);
    slot(1'b1, 1'b0, 10'h002);
    chk("run", st, 8'h0f);
    chk("runcmd", valid, 8'h01);
    finish_test;
  end
endmodule
